// ---- pdmo_pkg.sv ----
package pdmo_pkg;
   // Modulator sample width and accumulator width
   localparam int SAMPLE_W = 16;
   localparam int ACC_W = 20;
   // Sleep detection: clock below this rate means sleep
   localparam int SLEEP_HZ = 1000;
   localparam int CLK_HZ = 100_000_000;
   localparam int SLEEP_CYC = CLK_HZ / SLEEP_HZ;
   localparam int SLEEP_W = 17;
   // Strap level meaning
   localparam logic STRAP_RIGHT = 1'b0;
   localparam logic STRAP_LEFT = 1'b1;
   // Reset value of the data output
   localparam logic DATA_RST = 1'b0;

   // Pin group of the shared data line
   typedef struct packed {
      logic dataOut;
      logic dataOe;
   } pdmo_pin_t;

   // Sleep or run state
   typedef enum logic [1:0] {
      PDMO_SLEEP = 2'b01,
      PDMO_RUN = 2'b10
   } pdmo_state_t;
endpackage

// ---- pdmo_port.sv ----
`timescale 1ns/10ps
// Behaviour
// - Data pin carries one fourth-order modulator bit per clock, unframed
// - Left strap: new bit launched on falling clock edge
// - Right strap: new bit launched on rising clock edge
// - Drive during own half period, release to high impedance otherwise
// - Strap low selects right channel, right half-slot
// - Strap high selects left channel, left half-slot
// - Left and right devices share one wire and one clock
// - Alone on line, data changes only on own single edge
// - Many ones means near positive full scale
// - Many zeros means near negative full scale
// - Zero input gives alternating ones and zeros
// - Sleep on clock stop or below 1 kHz, output released
module pdmo_port
   import pdmo_pkg::*;
#(
   parameter int SLEEP_CYCLES = SLEEP_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic clkEn,
   input wire logic bitClk,
   input wire logic chanSel,
   input wire logic signed [pdmo_pkg::SAMPLE_W-1:0] audioIn,
   output pdmo_pkg::pdmo_pin_t dataPin,
   output logic asleep
);
   import pdmo_pkg::*;

   // Pin synchronisers and latched strap
   logic [2:0] clkSync_q, clkSync_d;
   logic [1:0] selSync_q, selSync_d;
   logic isLeft_q, isLeft_d;
   // Sleep detection and state
   logic [SLEEP_W-1:0] idleCnt_q, idleCnt_d;
   pdmo_state_t state_q, state_d;
   // Modulator integrators
   logic signed [ACC_W-1:0] int_q [4];
   logic signed [ACC_W-1:0] int_d [4];
   // Output bit and driver enable
   logic bit_q, bit_d;
   logic oe_q, oe_d;
   // Decoded clock edges and helpers
   logic rise, fall, launch, release_, sleepHit;
   logic signed [ACC_W-1:0] fb;
   logic signed [ACC_W-1:0] quant;

   // Edge detection reads only the second and third stages
   assign rise = clkSync_q[1] & ~clkSync_q[2];
   assign fall = ~clkSync_q[1] & clkSync_q[2];
   // Left launches on fall, right on rise
   assign launch = isLeft_q ? fall : rise;
   assign release_ = isLeft_q ? rise : fall;
   assign sleepHit = (idleCnt_q >= SLEEP_W'(SLEEP_CYCLES - 1));
   // Full-scale feedback: a one feeds back positive full scale
   assign fb = bit_q ? ACC_W'(32767) : -ACC_W'(32768);

   // Synchronisers, strap, idle counter and state
   always_comb begin
      clkSync_d = {clkSync_q[1:0], bitClk};
      selSync_d = {selSync_q[0], chanSel};
      isLeft_d = isLeft_q;
      idleCnt_d = idleCnt_q;
      state_d = state_q;
      if (rise) begin
         idleCnt_d = '0;
      end else if (!sleepHit) begin
         idleCnt_d = idleCnt_q + SLEEP_W'(1);
      end
      case (state_q)
         PDMO_SLEEP: begin
            isLeft_d = (selSync_q[1] == STRAP_LEFT);
            if (rise) begin
               state_d = PDMO_RUN;
            end
         end
         PDMO_RUN: begin
            if (sleepHit) begin
               state_d = PDMO_SLEEP;
            end
         end
         default: begin
            state_d = PDMO_SLEEP;
         end
      endcase
   end

   // Fourth-order modulator and output driver
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         int_d[i] = int_q[i];
      end
      bit_d = bit_q;
      oe_d = oe_q;
      quant = '0;
      // A launch edge that meets the sleep limit must not drive again
      if (state_q != PDMO_RUN || sleepHit) begin
         oe_d = 1'b0;
      end else if (launch) begin
         // First integrator takes input minus one-bit feedback
         int_d[0] = int_q[0] + ACC_W'(audioIn) - fb;
         // Each later stage smooths the one before it; bounded, so the loop is stable
         int_d[1] = int_q[1] + ((int_q[0] - int_q[1]) >>> 2);
         int_d[2] = int_q[2] + ((int_q[1] - int_q[2]) >>> 2);
         int_d[3] = int_q[3] + ((int_q[2] - int_q[3]) >>> 2);
         // Quantiser: sign decides the bit; zero input toggles
         quant = int_d[0] + (int_d[3] >>> 4);
         bit_d = (quant > 0) || (quant == 0 && !bit_q);
         oe_d = 1'b1;
      end else if (release_) begin
         oe_d = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clkSync_q <= '0;
         selSync_q <= '0;
         isLeft_q <= 1'b0;
         idleCnt_q <= '0;
         state_q <= PDMO_SLEEP;
         for (int i = 0; i < 4; i++) begin
            int_q[i] <= '0;
         end
         bit_q <= DATA_RST;
         oe_q <= 1'b0;
      end else if (clkEn) begin
         clkSync_q <= clkSync_d;
         selSync_q <= selSync_d;
         isLeft_q <= isLeft_d;
         idleCnt_q <= idleCnt_d;
         state_q <= state_d;
         for (int i = 0; i < 4; i++) begin
            int_q[i] <= int_d[i];
         end
         bit_q <= bit_d;
         oe_q <= oe_d;
      end
   end

   // Pin group driven as one word
   assign dataPin = pdmo_pin_t'{bit_q, oe_q};
   assign asleep = (state_q == PDMO_SLEEP);

   // Driver enable follows the launch and release edges
   launch_drive_a: assert property (@(posedge clk) disable iff (!arst_n)
      clkEn && state_q == PDMO_RUN && launch && !sleepHit |=> oe_q)
      else $error("driver not enabled after launch");
   release_hiz_a: assert property (@(posedge clk) disable iff (!arst_n)
      clkEn && release_ |=> !oe_q)
      else $error("driver not released");
   left_edge_a: assert property (@(posedge clk) disable iff (!arst_n)
      clkEn && isLeft_q && rise |=> $stable(bit_q))
      else $error("left data changed on rising edge");
   right_edge_a: assert property (@(posedge clk) disable iff (!arst_n)
      clkEn && !isLeft_q && fall |=> $stable(bit_q))
      else $error("right data changed on falling edge");
   sleep_hiz_a: assert property (@(posedge clk) disable iff (!arst_n)
      state_q == PDMO_SLEEP |-> !oe_q)
      else $error("driving while asleep");
   sleep_entry_a: assert property (@(posedge clk) disable iff (!arst_n)
      clkEn && state_q == PDMO_RUN && sleepHit |=> state_q == PDMO_SLEEP)
      else $error("sleep not entered");
   strap_left_a: assert property (@(posedge clk) disable iff (!arst_n)
      state_q == PDMO_RUN && isLeft_q |-> !(oe_q && clkSync_q[2]
      && clkSync_q[1] && $past(clkSync_q[2]) && $past(clkSync_q[1])
      && $past(oe_q,2) == 1'b0))
      else $error("left device driving in high phase");
   one_bit_a: assert property (@(posedge clk) disable iff (!arst_n)
      clkEn && state_q == PDMO_RUN && !launch |=> $stable(int_q[3]))
      else $error("modulator stepped off edge");

   // Strap is frozen while streaming
   strap_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
      state_q == PDMO_RUN |=> $stable(isLeft_q))
      else $error("strap changed while running");

   // Driver turns on only after a launch edge
   oe_rise_a: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(oe_q) |-> $past(clkEn && launch && state_q == PDMO_RUN))
      else $error("driver enabled without launch edge");

   // Driver turns off only on release, sleep or leaving run
   oe_fall_a: assert property (@(posedge clk) disable iff (!arst_n)
      $fell(oe_q) |-> $past(clkEn && (release_ || sleepHit
      || state_q != PDMO_RUN)))
      else $error("driver released at wrong time");

   // A new bit only appears while the driver is on
   data_driven_a: assert property (@(posedge clk) disable iff (!arst_n)
      $changed(bit_q) |-> oe_q)
      else $error("data changed while released");

   // Reaching the sleep limit releases the line
   sleep_release_a: assert property (@(posedge clk) disable iff (!arst_n)
      clkEn && sleepHit |=> !oe_q)
      else $error("line driven at sleep limit");

   // A rising clock edge wakes the port
   wake_rise_a: assert property (@(posedge clk) disable iff (!arst_n)
      clkEn && state_q == PDMO_SLEEP && rise |=> state_q == PDMO_RUN)
      else $error("no wake on rising edge");

   // Main scenarios
   wake_c: cover property (@(posedge clk) state_q == PDMO_SLEEP
      ##1 state_q == PDMO_RUN);
   left_c: cover property (@(posedge clk) isLeft_q && oe_q);
   right_c: cover property (@(posedge clk) !isLeft_q && oe_q);
   sleep_c: cover property (@(posedge clk) state_q == PDMO_RUN
      ##1 state_q == PDMO_SLEEP);
endmodule

// ---- pdmo_codec.sv ----
`timescale 1ns/10ps
module pdmo_codec
   import pdmo_pkg::*;
(
   input wire logic run,
   input wire logic clr,
   input pdmo_pkg::pdmo_pin_t pin,
   output logic bitClk,
   output logic lineLvl,
   output int hiBits,
   output int loBits,
   output int ones
);
   logic last = 1'b0;
   // Released wire shows the inverse of the last driven bit
   assign lineLvl = pin.dataOe ? pin.dataOut : ~last;
   always @(pin) if (pin.dataOe) last = pin.dataOut;
   // 160 ns clock, parked low when stopped; capture late in each half
   initial begin
      bitClk = 1'b0;
      forever begin
         #75;
         if (clr) begin
            hiBits = 0;
            loBits = 0;
            ones = 0;
         end else if (pin.dataOe) begin
            if (bitClk) hiBits++;
            else loBits++;
            ones += int'(lineLvl);
         end
         #5;
         if (run || bitClk) bitClk = ~bitClk;
      end
   end
endmodule

// ---- pdm_mic_output_port_bench.sv ----
`timescale 1ns/10ps
module pdm_mic_output_port_bench;
   import pdmo_pkg::*;
   typedef struct {logic sel; logic [15:0] smp; int kind;} pdmo_row_t;
   logic clk, arst_n, chanSel, run, clr, asleep, bitClk, lineLvl;
   logic signed [SAMPLE_W-1:0] audioIn;
   pdmo_pin_t dataPin;
   int hiBits, loBits, ones, failures, tests_run, n;
   pdmo_row_t rows [4] = '{'{STRAP_RIGHT, 16'h6000, 2},
      '{STRAP_LEFT, 16'h0000, 1}, '{STRAP_LEFT, 16'h6000, 2},
      '{STRAP_RIGHT, 16'hA000, 0}};
   pdmo_port #(.SLEEP_CYCLES(64)) uut (.clk(clk), .arst_n(arst_n),
      .clkEn(1'b1), .bitClk(bitClk), .chanSel(chanSel),
      .audioIn(audioIn), .dataPin(dataPin), .asleep(asleep));
   pdmo_codec codec (.run(run), .clr(clr), .pin(dataPin),
      .bitClk(bitClk), .lineLvl(lineLvl), .hiBits(hiBits),
      .loBits(loBits), .ones(ones));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(input logic seen, input logic exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t mismatch", $time);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   // Clear the capture counts in the codec
   task automatic zero();
      clr = 1'b1;
      tick(20);
      clr = 1'b0;
   endtask
   // Watchdog
   initial begin
      #300000;
      failures++;
      wrap_up();
   end
   initial begin
      failures = 0;
      tests_run = 0;
      arst_n = 1'b0;
      run = 1'b0;
      clr = 1'b0;
      chanSel = STRAP_RIGHT;
      audioIn = '0;
      tick(10);
      arst_n = 1'b1;
      foreach (rows[i]) begin
         run = 1'b0;
         tick(120);
         check(asleep, 1'b1);
         check(dataPin.dataOe, 1'b0);
         chanSel = rows[i].sel;
         audioIn = rows[i].smp;
         zero();
         run = 1'b1;
         tick(1040);
         n = hiBits + loBits;
         check(rows[i].sel ? hiBits == 0 : loBits == 0, 1'b1);
         check((rows[i].sel ? loBits : hiBits) > 55, 1'b1);
         case (rows[i].kind)
            0: check(ones * 4 < n, 1'b1);
            1: check(ones * 8 > n * 3 && ones * 8 < n * 5, 1'b1);
            default: check(ones * 4 > n * 3, 1'b1);
         endcase
         $display("row %0d done", i);
      end
      // Strap moved while streaming keeps the right half-slot
      chanSel = STRAP_LEFT;
      zero();
      tick(400);
      check(loBits == 0 && hiBits > 15, 1'b1);
      $display("strap test done");
      // Reset in mid-stream releases the line and sleeps
      arst_n = 1'b0;
      tick(2);
      check(asleep, 1'b1);
      check(dataPin.dataOe, 1'b0);
      arst_n = 1'b1;
      tick(1);
      check(asleep, 1'b1);
      check(dataPin.dataOe, 1'b0);
      $display("reset test done");
      wrap_up();
   end
endmodule
